// ---- calib_timer_params.svh ----
/*
 Constants of the calibrated interval timer: interval steps, reset values,
 measurement loop length and the event-count formula.
 Assumes it is included by bare name wherever a figure is needed.
*/
`ifndef CALIB_TIMER_PARAMS_SVH
`define CALIB_TIMER_PARAMS_SVH

`define CT_BASE_MS 100
`define CT_MAX_MS 500
`define CT_SEL_MAX 3'h5
`define CT_SEL_RESET 3'h1
`define CT_LOOP_CLKS 7
`define CT_PRE_LAST 3'h6
`define CT_BYTE_MSB 14
`define CT_BYTE_LSB 7
`define CT_CALC_OFFSET 9'h042
`define CT_CALC_THRESH 8'h1C
`define CT_EVENTS_MIN 8'h1B
`define CT_EVENTS_MAX 8'h24
`define CT_BASE_RESET 8'h00
`define CT_LED_RESET 1'b0

`endif

// ---- calib_timer_pkg.sv ----
/*
 Types shared by the calibrated interval timer and its helpers.
 Assumes calib_timer_params.svh is on the include path.
*/
package calib_timer_pkg;
	typedef enum logic [1:0] {ST_COUNT, ST_MEASURE} timer_state_t;
	typedef logic [2:0] sel_t;
	typedef logic [7:0] events_t;
	typedef logic [15:0] meas_t;
endpackage

// ---- meter_if.sv ----
/*
 Link between the timer controller and the period meter.
 Assumes both ends run on the same clock and reset.
*/
`timescale 1ns/1ps
interface meter_if;
	import calib_timer_pkg::*;
	logic start;
	logic stop;
	logic done;
	events_t events;
	meas_t count;
	modport ctrl(output start, output stop, input done, input events, input count);
	modport meter(input start, input stop, output done, output events, output count);
endinterface

// ---- sync_edge.sv ----
/*
 Two-flop synchroniser followed by a rising-edge detector.
 Assumes d_async may change at any time relative to ref_clk.
*/
`timescale 1ns/1ps
module sync_edge (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic d_async,
	output logic pulse
);
	logic [2:0] sh_r;
	logic [2:0] sh_nxt;

	always_comb begin
		sh_nxt = {sh_r[1:0], d_async};
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sh_r <= 3'h0;
		end else begin
			sh_r <= sh_nxt;
		end
	end

	// Edge taken from second and third stages only
	assign pulse = sh_r[1] & ~sh_r[2];
endmodule

// ---- period_meter.sv ----
/*
 Measures one watchdog event period in loop units and converts it to the
 number of events per base period.
 Assumes start and stop are one-cycle pulses from the controller.
*/
`timescale 1ns/1ps
`include "calib_timer_params.svh"
module period_meter (
	input wire logic ref_clk,
	input wire logic rst,
	meter_if.meter m
);
	import calib_timer_pkg::*;

	function automatic events_t calc_events(input meas_t c);
		logic [8:0] diff;
		logic [7:0] v;
		diff = `CT_CALC_OFFSET - {1'b0, c[`CT_BYTE_MSB:`CT_BYTE_LSB]};
		v = diff[7:0];
		if (diff[8]) begin
			v = `CT_EVENTS_MIN;
		end else if (v < `CT_CALC_THRESH) begin
			v = v + 8'h01;
		end
		if (v < `CT_EVENTS_MIN) begin
			v = `CT_EVENTS_MIN;
		end else if (v > `CT_EVENTS_MAX) begin
			v = `CT_EVENTS_MAX;
		end
		return v;
	endfunction

	logic busy_r, busy_nxt;
	logic done_r, done_nxt;
	logic [2:0] pre_r, pre_nxt;
	meas_t cnt_r, cnt_nxt;
	events_t ev_r, ev_nxt;

	always_comb begin
		busy_nxt = busy_r;
		pre_nxt = pre_r;
		cnt_nxt = cnt_r;
		ev_nxt = ev_r;
		done_nxt = 1'b0;
		if (m.start) begin
			busy_nxt = 1'b1;
			pre_nxt = 3'h0;
			cnt_nxt = 16'h0000;
		end else if (busy_r && m.stop) begin
			busy_nxt = 1'b0;
			done_nxt = 1'b1;
			ev_nxt = calc_events(cnt_r);
		end else if (busy_r) begin
			if (pre_r == `CT_PRE_LAST) begin
				pre_nxt = 3'h0;
				if (cnt_r != 16'hFFFF) begin
					cnt_nxt = cnt_r + 16'h0001;
				end
			end else begin
				pre_nxt = pre_r + 3'h1;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			busy_r <= 1'b0;
			done_r <= 1'b0;
			pre_r <= 3'h0;
			cnt_r <= 16'h0000;
			ev_r <= `CT_EVENTS_MIN;
		end else begin
			busy_r <= busy_nxt;
			done_r <= done_nxt;
			pre_r <= pre_nxt;
			cnt_r <= cnt_nxt;
			ev_r <= ev_nxt;
		end
	end

	assign m.done = done_r;
	assign m.events = ev_r;
	assign m.count = cnt_r;

	meas_step_a: assert property (@(posedge ref_clk) disable iff (rst)
		busy_r && !m.stop && !m.start && pre_r == `CT_PRE_LAST && cnt_r != 16'hFFFF
		|=> cnt_r == $past(cnt_r) + 16'h0001)
		else $error("measure count did not advance after seven clocks");
	ev_range_a: assert property (@(posedge ref_clk) disable iff (rst)
		m.done |-> (m.events >= 8'h1B && m.events <= 8'h24))
		else $error("event count out of range");
	ev_calc_a: assert property (@(posedge ref_clk) disable iff (rst)
		m.done |-> m.events == calc_events(m.count))
		else $error("event count does not match measured period");
endmodule

// ---- calibrated_interval_timer.sv ----
/*
 Interval timer that toggles an LED every 100..500 ms, with a 100 ms base
 built from watchdog interval events and recalibrated by period measurement.
 Assumes watchdog_interval_event and selection_switch are asynchronous levels
 whose rising edges mark an event or a press.
*/
// Notes on behaviour
// - Selected interval runs 100 ms to 500 ms in 100 ms steps.
// - Base period counts watchdog events; the count per period is recalibrated.
// - LED output inverts each time the selected interval fully elapses.
// - Reset selects 100 ms; each press below 500 ms adds another 100 ms.
// - A press while at 500 ms wraps back to 100 ms.
// - Every press raises the key event and increments the press count.
// - Base counter reaching zero decrements the interval counter, or reloads it from the selection when it is at one.
// - Watchdog event with base counter at zero starts a calibration pass.
// - Calibration counts until the next watchdog event, holding at FFFF.
// - Measured period gives the event count loaded into the base counter.
// - Outside calibration each watchdog event with a nonzero base counter decrements it.
// - Clear watchdog counter in the same cycle the measurement starts; measure count advances every seven clocks.
// - Events equal 66 minus count bits 14..7, plus one below 28.
// - Events per base period stay within 27 through 36.
`timescale 1ns/1ps
`include "calib_timer_params.svh"
module calibrated_interval_timer #(
	parameter int PRESS_W = 8
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic watchdog_interval_event,
	input wire logic selection_switch,
	output logic led_drive,
	output logic key_press_event,
	output logic watchdog_counter_clear,
	output logic [PRESS_W-1:0] press_count,
	output calib_timer_pkg::sel_t interval_sel,
	output calib_timer_pkg::events_t base_count,
	output logic calibrating
);
	import calib_timer_pkg::*;

	logic wd_pulse;
	logic key_pulse;

	timer_state_t state_r, state_nxt;
	events_t base_r, base_nxt;
	sel_t ivl_r, ivl_nxt;
	sel_t sel_r, sel_nxt;
	logic led_r, led_nxt;
	logic [PRESS_W-1:0] press_r, press_nxt;
	logic clr_r, clr_nxt;
	logic key_r, key_nxt;

	meter_if mi();

	sync_edge u_wd_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.d_async(watchdog_interval_event),
		.pulse(wd_pulse)
	);

	sync_edge u_key_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.d_async(selection_switch),
		.pulse(key_pulse)
	);

	period_meter u_meter (
		.ref_clk(ref_clk),
		.rst(rst),
		.m(mi.meter)
	);

	// Selection and press bookkeeping
	always_comb begin
		sel_nxt = sel_r;
		press_nxt = press_r;
		key_nxt = 1'b0;
		if (key_pulse) begin
			key_nxt = 1'b1;
			press_nxt = press_r + PRESS_W'(1);
			if (sel_r == `CT_SEL_MAX) begin
				sel_nxt = `CT_SEL_RESET;
			end else begin
				sel_nxt = sel_r + 3'h1;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sel_r <= `CT_SEL_RESET;
			press_r <= '0;
			key_r <= 1'b0;
		end else begin
			sel_r <= sel_nxt;
			press_r <= press_nxt;
			key_r <= key_nxt;
		end
	end

	// Base counting, interval counting and calibration control
	always_comb begin
		state_nxt = state_r;
		base_nxt = base_r;
		ivl_nxt = ivl_r;
		led_nxt = led_r;
		clr_nxt = 1'b0;
		mi.start = 1'b0;
		mi.stop = 1'b0;
		unique case (state_r)
			ST_COUNT: begin
				if (wd_pulse) begin
					if (base_r == `CT_BASE_RESET) begin
						clr_nxt = 1'b1;
						mi.start = 1'b1;
						state_nxt = ST_MEASURE;
					end else begin
						base_nxt = base_r - 8'h01;
						if (base_r == 8'h01) begin
							if (ivl_r <= 3'h1) begin
								led_nxt = ~led_r;
								ivl_nxt = sel_r;
							end else begin
								ivl_nxt = ivl_r - 3'h1;
							end
						end
					end
				end
			end
			ST_MEASURE: begin
				mi.stop = wd_pulse;
				if (mi.done) begin
					base_nxt = mi.events;
					state_nxt = ST_COUNT;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_COUNT;
			base_r <= `CT_BASE_RESET;
			ivl_r <= `CT_SEL_RESET;
			led_r <= `CT_LED_RESET;
			clr_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			base_r <= base_nxt;
			ivl_r <= ivl_nxt;
			led_r <= led_nxt;
			clr_r <= clr_nxt;
		end
	end

	assign led_drive = led_r;
	assign key_press_event = key_r;
	assign watchdog_counter_clear = clr_r;
	assign press_count = press_r;
	assign interval_sel = sel_r;
	assign base_count = base_r;
	assign calibrating = (state_r == ST_MEASURE);

	// Checks
	sel_range_a: assert property (@(posedge ref_clk) disable iff (rst)
		sel_r >= 3'h1 && sel_r <= 3'h5)
		else $error("selection outside 100..500 ms");

	sel_step_a: assert property (@(posedge ref_clk) disable iff (rst)
		key_pulse && sel_r != 3'h5 |=> sel_r == $past(sel_r) + 3'h1)
		else $error("press did not add one step");

	sel_wrap_a: assert property (@(posedge ref_clk) disable iff (rst)
		key_pulse && sel_r == 3'h5 |=> sel_r == 3'h1)
		else $error("press at 500 ms did not wrap");

	press_seen_a: assert property (@(posedge ref_clk) disable iff (rst)
		key_pulse |=> key_press_event && press_count == $past(press_count) + PRESS_W'(1))
		else $error("press not counted or not signalled");

	led_cause_a: assert property (@(posedge ref_clk) disable iff (rst)
		led_drive != $past(led_drive) |-> $past(state_r == ST_COUNT && wd_pulse
		&& base_r == 8'h01 && ivl_r <= 3'h1))
		else $error("LED changed without interval expiry");

	led_toggle_a: assert property (@(posedge ref_clk) disable iff (rst)
		state_r == ST_COUNT && wd_pulse && base_r == 8'h01 && ivl_r <= 3'h1
		|=> led_drive == !$past(led_drive))
		else $error("LED did not invert at interval expiry");

	ivl_dec_a: assert property (@(posedge ref_clk) disable iff (rst)
		state_r == ST_COUNT && wd_pulse && base_r == 8'h01 && ivl_r > 3'h1
		|=> ivl_r == $past(ivl_r) - 3'h1)
		else $error("interval counter not decremented");

	ivl_reload_a: assert property (@(posedge ref_clk) disable iff (rst)
		state_r == ST_COUNT && wd_pulse && base_r == 8'h01 && ivl_r <= 3'h1
		|=> ivl_r == $past(sel_r))
		else $error("interval counter not reloaded");

	cal_start_a: assert property (@(posedge ref_clk) disable iff (rst)
		state_r == ST_COUNT && wd_pulse && base_r == 8'h00
		|=> calibrating && watchdog_counter_clear ##1 !watchdog_counter_clear)
		else $error("calibration not started on zero base count");

	base_dec_a: assert property (@(posedge ref_clk) disable iff (rst)
		state_r == ST_COUNT && wd_pulse && base_r != 8'h00
		|=> base_count == $past(base_count) - 8'h01 && !calibrating)
		else $error("base counter not decremented");

	base_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		calibrating && !mi.done |=> base_count == $past(base_count))
		else $error("base counter moved during measurement");

	base_load_a: assert property (@(posedge ref_clk) disable iff (rst)
		calibrating && mi.done |=> base_count == $past(mi.events) && !calibrating)
		else $error("base counter not loaded from measurement");

	cal_end_a: assert property (@(posedge ref_clk) disable iff (rst)
		calibrating && wd_pulse |-> ##[1:2] !calibrating)
		else $error("calibration did not end after the next event");

	sel_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		!key_pulse |=> $stable(sel_r))
		else $error("selection changed without a press");

	press_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		!key_pulse |=> !key_press_event && $stable(press_count))
		else $error("press count moved without a press");

	key_single_a: assert property (@(posedge ref_clk) disable iff (rst)
		key_press_event |=> !key_press_event)
		else $error("key event lasted more than one cycle");

	ivl_range_a: assert property (@(posedge ref_clk) disable iff (rst)
		ivl_r >= `CT_SEL_RESET && ivl_r <= `CT_SEL_MAX)
		else $error("interval counter outside one to five steps");

	ivl_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		!(state_r == ST_COUNT && wd_pulse && base_r == 8'h01) |=> $stable(ivl_r))
		else $error("interval counter moved inside a base period");

	ivl_calm_a: assert property (@(posedge ref_clk) disable iff (rst)
		calibrating |=> $stable(ivl_r))
		else $error("interval counter moved during measurement");

	led_calm_a: assert property (@(posedge ref_clk) disable iff (rst)
		calibrating |=> $stable(led_drive))
		else $error("LED changed during measurement");

	base_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
		state_r == ST_COUNT && !wd_pulse |=> $stable(base_count))
		else $error("base counter moved without an event");

	event_single_a: assert property (@(posedge ref_clk) disable iff (rst)
		wd_pulse |=> !wd_pulse)
		else $error("one watchdog event taken twice");

	base_max_a: assert property (@(posedge ref_clk) disable iff (rst)
		base_count <= `CT_EVENTS_MAX)
		else $error("base counter above the largest event count");

	load_range_a: assert property (@(posedge ref_clk) disable iff (rst)
		calibrating && mi.done |=> base_count >= `CT_EVENTS_MIN)
		else $error("loaded event count below the smallest one");

	cal_entry_a: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(calibrating) |-> $past(wd_pulse && base_r == 8'h00))
		else $error("calibration entered without a zero base count");

	count_stay_a: assert property (@(posedge ref_clk) disable iff (rst)
		state_r == ST_COUNT && !wd_pulse |=> !calibrating)
		else $error("calibration started without an event");

	meas_stay_a: assert property (@(posedge ref_clk) disable iff (rst)
		calibrating && !wd_pulse && !mi.done |=> calibrating)
		else $error("measurement ended before the next event");

	cal_stop_a: assert property (@(posedge ref_clk) disable iff (rst)
		calibrating && wd_pulse && !mi.done |=> mi.done)
		else $error("next event did not stop the measurement");

	clr_cause_a: assert property (@(posedge ref_clk) disable iff (rst)
		watchdog_counter_clear |-> calibrating && $past(wd_pulse && base_r == 8'h00))
		else $error("counter clear outside a calibration start");

	clr_single_a: assert property (@(posedge ref_clk) disable iff (rst)
		watchdog_counter_clear |=> !watchdog_counter_clear)
		else $error("counter clear longer than one cycle");

	led_toggle_c: cover property (@(posedge ref_clk) disable iff (rst)
		led_drive != $past(led_drive));
	sel_wrap_c: cover property (@(posedge ref_clk) disable iff (rst)
		key_pulse && sel_r == 3'h5);
	cal_done_c: cover property (@(posedge ref_clk) disable iff (rst)
		calibrating && mi.done);
	long_ivl_c: cover property (@(posedge ref_clk) disable iff (rst)
		sel_r == 3'h5 && ivl_r == 3'h1 && base_r == 8'h01 && wd_pulse);
	ivl_step_c: cover property (@(posedge ref_clk) disable iff (rst)
		state_r == ST_COUNT && wd_pulse && base_r == 8'h01 && ivl_r > 3'h1);
endmodule

// ---- board_model.sv ----
/*
 Board-side model: watchdog interval event source and push-button switch.
 Assumes the timer samples both lines on the rising edge of ref_clk; both
 lines idle low, as with a pull-down, between events and presses.
*/
`timescale 1ns/1ps
module board_model (
	input wire logic ref_clk,
	output logic watchdog_interval_event,
	output logic selection_switch
);
	initial begin
		watchdog_interval_event = 1'b0;
		selection_switch = 1'b0;
	end

	// Event rises gap minus two clocks after the call, held high two clocks
	task automatic tick(input int gap);
		repeat (gap - 2) @(negedge ref_clk);
		watchdog_interval_event = 1'b1;
		repeat (2) @(negedge ref_clk);
		watchdog_interval_event = 1'b0;
	endtask

	// One clean press, then released long enough to settle
	task automatic press();
		@(negedge ref_clk);
		selection_switch = 1'b1;
		repeat (4) @(negedge ref_clk);
		selection_switch = 1'b0;
		repeat (4) @(negedge ref_clk);
	endtask
endmodule

// ---- tb.sv ----
/*
 Self-checking testbench of the calibrated interval timer.
 Assumes the board model drives the event and switch lines at falling edges.
*/
`timescale 1ns/1ps
module tb;
	import calib_timer_pkg::*;
	logic ref_clk;
	logic rst;
	logic watchdog_interval_event;
	logic selection_switch;
	logic led_drive;
	logic key_press_event;
	logic watchdog_counter_clear;
	logic calibrating;
	logic [7:0] press_count;
	sel_t interval_sel;
	events_t base_count;
	logic led_exp;
	int error_cnt = 0;
	int comparisons = 0;
	int cycles = 0;
	int kp_cnt = 0;
	int clr_cnt = 0;
	int gaps[3] = '{400, 36288, 30912};
	int evs[3] = '{36, 27, 32};

	calibrated_interval_timer #(.PRESS_W(8)) calibrated_interval_timer_i (
		.ref_clk(ref_clk),
		.rst(rst),
		.watchdog_interval_event(watchdog_interval_event),
		.selection_switch(selection_switch),
		.led_drive(led_drive),
		.key_press_event(key_press_event),
		.watchdog_counter_clear(watchdog_counter_clear),
		.press_count(press_count),
		.interval_sel(interval_sel),
		.base_count(base_count),
		.calibrating(calibrating)
	);

	board_model board_model_i (
		.ref_clk(ref_clk),
		.watchdog_interval_event(watchdog_interval_event),
		.selection_switch(selection_switch)
	);

	always #5 ref_clk = ~ref_clk;

	// One-cycle pulses are counted where they are settled
	always @(negedge ref_clk) begin
		if (key_press_event === 1'b1) kp_cnt++;
		if (watchdog_counter_clear === 1'b1) clr_cnt++;
	end

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 100000) begin
			error_cnt++;
			$display("Error at %0t: timeout", $time);
			tally_and_finish();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Calibration pass measured over gap clocks, then n events down to zero
	task automatic base_period(input int gap, input int n, input logic toggles);
		int c0;
		c0 = clr_cnt;
		board_model_i.tick(20);
		repeat (3) @(negedge ref_clk);
		check(16'(calibrating), 16'h0001, "calibration start");
		check(16'(clr_cnt - c0), 16'h0001, "counter clear pulse");
		board_model_i.tick(gap);
		repeat (4) @(negedge ref_clk);
		check(16'(calibrating), 16'h0000, "calibration end");
		check(16'(base_count), 16'(n), "events per base period");
		for (int i = n - 1; i >= 0; i--) begin
			board_model_i.tick(20);
			repeat (4) @(negedge ref_clk);
			check(16'(base_count), 16'(i), "base countdown");
		end
		if (toggles) led_exp = ~led_exp;
		check(16'(led_drive), 16'(led_exp), "led level");
	endtask

	task automatic t_press();
		int k0;
		k0 = kp_cnt;
		for (int i = 0; i < 5; i++) begin
			board_model_i.press();
			check(16'(interval_sel), 16'(i == 4 ? 1 : i + 2), "selection step");
		end
		check(16'(kp_cnt - k0), 16'h0005, "key events");
		check(16'(press_count), 16'h0005, "press count");
		$display("Test press done");
	endtask

	task automatic t_reset();
		repeat (5) @(negedge ref_clk);
		rst = 1'b0;
		@(negedge ref_clk);
		check(16'(interval_sel), 16'h0001, "reset selection");
		check(16'(base_count), 16'h0000, "reset base");
		check(16'(led_drive), 16'h0000, "reset led");
		check(16'(press_count), 16'h0000, "reset presses");
		$display("Test reset done");
	endtask

	task automatic t_calibration();
		for (int t = 0; t < 3; t++) begin
			base_period(gaps[t], evs[t], 1'b1);
		end
		$display("Test calibration done");
	endtask

	task automatic t_interval();
		board_model_i.press();
		check(16'(interval_sel), 16'h0002, "select 200");
		// Old reload of one still pending, then two base periods per toggle
		base_period(400, 36, 1'b1);
		base_period(400, 36, 1'b0);
		base_period(400, 36, 1'b1);
		$display("Test interval done");
	endtask

	initial begin
		ref_clk = 1'b0;
		rst = 1'b1;
		led_exp = 1'b0;
		t_reset();
		t_calibration();
		t_press();
		t_interval();
		tally_and_finish();
	end
endmodule
